// ---- rtl/ppm_port_pin_function_mux.v ----
// Operation
// [RULE1] Each pin switches between port and alternate; port 7 has no alternate select in the code
// [RULE2] Port 0 bits 0,4 input; 1-3 bidirectional
// [RULE3] Port 0 bits 1-3 direction per bit
// [RULE4] Port 0 pull-up only when input and enabled
// [RULE5] Interrupts 0-2 select rising, falling or both
// [RULE6] Valid interrupt 0 edge triggers timer capture
// [RULE7] Interrupt 3 detects falling edges only
// [RULE8] Port 1 direction per bit from register
// [RULE9] Analog-selected port 1 pin drops its pull-up
// [RULE10] Software programs port 2 for serial roles
// [RULE11] Port 3 direction per bit; timer/clock/beeper alternates
// [RULE12] Port 7 five open-drain bidirectional bits
// [RULE13] Port 8 two outputs; alternate digits 0-1
// [RULE14] Port 9 eight outputs; alternate digits 2-9
// [RULE15] Port 10 outputs; digit/segment and segment alternates
// [RULE16] Ports 11,12 bidirectional; segments 18-33 alternate
// [RULE17] Programming mode on high-voltage pin or reset low
// [RULE18] Alternate selects clear to port mode at reset
`include "ppm_map.vh"
`default_nettype none
module ppm_port_pin_function_mux (
    input wire clock,
    input wire reset_n,
    input wire [4:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdata,
    output wire irqOut,
    input wire [4:0] port0PinIn,
    output wire [4:0] port0PinOut,
    output wire [4:0] port0PinOe,
    output wire [4:0] port0PullupEn,
    input wire [7:0] port1PinIn,
    output wire [7:0] port1PinOut,
    output wire [7:0] port1PinOe,
    output wire [7:0] port1PullupEn,
    output wire [7:0] analogIn,
    input wire [7:0] port2PinIn,
    output wire [7:0] port2PinOut,
    output wire [7:0] port2PinOe,
    output wire [7:0] port2PullupEn,
    input wire [7:0] serialOut,
    input wire [7:0] serialOe,
    output wire [7:0] serialIn,
    input wire [7:0] port3PinIn,
    output wire [7:0] port3PinOut,
    output wire [7:0] port3PinOe,
    output wire [7:0] port3PullupEn,
    input wire [2:0] timerOutPins,
    input wire clockOutPin,
    input wire beeperOutput,
    output wire timer8CountIn1,
    output wire timer8CountIn2,
    input wire [4:0] port7PinIn,
    output wire [4:0] port7PinOut,
    output wire [4:0] port7PinOe,
    output wire [1:0] port8PinOut,
    output wire [7:0] port9PinOut,
    output wire [7:0] port10PinOut,
    input wire [7:0] port11PinIn,
    output wire [7:0] port11PinOut,
    output wire [7:0] port11PinOe,
    input wire [7:0] port12PinIn,
    output wire [7:0] port12PinOut,
    output wire [7:0] port12PinOe,
    input wire [33:0] displayDrivePins,
    output wire [3:0] extIrqPulse,
    output wire timer16CaptureTrig,
    output wire timer16CountIn,
    output wire updownCountIn,
    output wire subclockCrystalIn,
    input wire progVoltagePin,
    output wire romProgMode
);

reg rstMeta_r;
reg rstSync_r;
wire rstN;

// Reset enters asynchronously but releases on the clock
always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        rstMeta_r <= 1'b0;
        rstSync_r <= 1'b0;
    end
    else
    begin
        rstMeta_r <= 1'b1;
        rstSync_r <= rstMeta_r;
    end
end
assign rstN = rstSync_r;

// Programming pin is asynchronous; it passes two flops like any pin
reg progMeta_r;
reg progSync_r;
always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        progMeta_r <= 1'b0;
        progSync_r <= 1'b0;
    end
    else
    begin
        progMeta_r <= progVoltagePin;
        progSync_r <= progMeta_r;
    end
end

// Reset low must enter the mode at once, even with no clock running
assign romProgMode = progSync_r | ~reset_n; // [RULE17]

reg [7:0] p0Out_r, p0Dir_r, pullup_r, p1Out_r, p1Dir_r, p2Out_r, p2Dir_r;
reg [7:0] p3Out_r, p3Dir_r, p7Out_r, p7Dir_r, p8Out_r, p9Out_r, p10Out_r;
reg [7:0] p11Out_r, p11Dir_r, p12Out_r, p12Dir_r;
reg [7:0] alt0_r, alt1_r, alt2_r, alt3_r, alt89_r, alt10_r, alt11_r;
reg [7:0] alt12_r, edge_r, irqSt_r, irqMsk_r;

// Pin inputs: two-stage synchronisers
wire [52:0] pinRaw;
reg [52:0] pinMeta_r;
reg [52:0] pinSync_r;
assign pinRaw = {port12PinIn, port11PinIn, port7PinIn, port3PinIn,
    port2PinIn, port1PinIn, port0PinIn};
always @(posedge clock or negedge rstN)
begin
    if (!rstN)
    begin
        pinMeta_r <= 53'h0;
        pinSync_r <= 53'h0;
    end
    else
    begin
        pinMeta_r <= pinRaw;
        pinSync_r <= pinMeta_r;
    end
end
wire [4:0] p0In = pinSync_r[4:0];
wire [7:0] p1In = pinSync_r[12:5];
wire [7:0] p2In = pinSync_r[20:13];
wire [7:0] p3In = pinSync_r[28:21];
wire [4:0] p7In = pinSync_r[33:29];
wire [7:0] p11In = pinSync_r[41:34];
wire [7:0] p12In = pinSync_r[49:42];

// Edge detect on the synchronised port 0 interrupt pins
reg [3:0] irqPrev_r;
wire [3:0] irqLvl = p0In[3:0];
wire [3:0] rise = irqLvl & ~irqPrev_r;
wire [3:0] fall = ~irqLvl & irqPrev_r;
reg [3:0] irqHit;
integer k;
always @*
begin
    for (k = 0; k < 3; k = k + 1)
    begin
        case (edge_r[2*k +: 2])
            `PPM_EDGE_RISE: irqHit[k] = rise[k]; // [RULE5]
            `PPM_EDGE_BOTH: irqHit[k] = rise[k] | fall[k]; // [RULE5]
            default: irqHit[k] = fall[k]; // [RULE5]
        endcase
    end
    irqHit[3] = fall[3]; // [RULE7]
end
// Only alternate-selected pins raise interrupts
assign extIrqPulse = irqHit & alt0_r[3:0]; // [RULE1]
assign timer16CaptureTrig = extIrqPulse[0]; // [RULE6]
assign timer16CountIn = p0In[0] & alt0_r[0];
assign updownCountIn = p0In[3] & alt0_r[3];
// Sampled through the pin synchroniser like every other pin
assign subclockCrystalIn = p0In[4] & alt0_r[4];

always @(posedge clock or negedge rstN)
begin
    if (!rstN)
        irqPrev_r <= 4'h0;
    else
        irqPrev_r <= irqLvl;
end

// Port 0: bits 0 and 4 never drive
assign port0PinOut = {1'b0, p0Out_r[3:1], 1'b0};
assign port0PinOe = {1'b0, ~p0Dir_r[3:1] & ~alt0_r[3:1], 1'b0}; // [RULE2] [RULE3]
assign port0PullupEn = ~port0PinOe & pullup_r[4:0]; // [RULE4]

// Port 1: direction register 1 means input; analog kills pull-up
assign port1PinOut = p1Out_r;
assign port1PinOe = ~p1Dir_r & ~alt1_r; // [RULE8]
assign port1PullupEn = ~port1PinOe & ~alt1_r & {8{pullup_r[5]}}; // [RULE9]
assign analogIn = p1In & alt1_r;

// Port 2: serial block drives output and enable on alternate-selected pins
assign port2PinOut = (alt2_r & serialOut) | (~alt2_r & p2Out_r); // [RULE10]
assign port2PinOe = (alt2_r & serialOe) | (~alt2_r & ~p2Dir_r);
assign port2PullupEn = ~port2PinOe & {8{pullup_r[6]}};
assign serialIn = p2In & alt2_r;

// Port 3: bits 0-2 timers, 5 clock, 6 beeper out; 3,4 timer inputs
wire [7:0] p3Alt = {1'b0, beeperOutput, clockOutPin, 2'b00, timerOutPins};
assign port3PinOut = (alt3_r & p3Alt) | (~alt3_r & p3Out_r); // [RULE11]
assign port3PinOe = ~p3Dir_r; // [RULE11]
assign port3PullupEn = ~port3PinOe & {8{pullup_r[7]}};
assign timer8CountIn1 = p3In[3] & alt3_r[3];
assign timer8CountIn2 = p3In[4] & alt3_r[4];

// Port 7: open drain, only ever pulls low
assign port7PinOut = 5'h00;
assign port7PinOe = ~p7Dir_r[4:0] & ~p7Out_r[4:0]; // [RULE12]

// Display ports: 8-10 output only, 11 and 12 bidirectional
// Port 9 takes the whole select byte, so port 8 selects ride in its latch
genvar g;
generate
    for (g = 0; g < 8; g = g + 1)
    begin : gDisp
        assign port9PinOut[g] = alt89_r[g] ? displayDrivePins[g+2]
            : p9Out_r[g]; // [RULE14]
        assign port10PinOut[g] = alt10_r[g] ? displayDrivePins[g+10]
            : p10Out_r[g]; // [RULE15]
        assign port11PinOut[g] = alt11_r[g] ? displayDrivePins[g+18]
            : p11Out_r[g]; // [RULE16]
        assign port11PinOe[g] = alt11_r[g] | ~p11Dir_r[g]; // [RULE16]
        assign port12PinOut[g] = alt12_r[g] ? displayDrivePins[g+26]
            : p12Out_r[g]; // [RULE16]
        assign port12PinOe[g] = alt12_r[g] | ~p12Dir_r[g]; // [RULE16]
    end
    for (g = 0; g < 2; g = g + 1)
    begin : gDig
        assign port8PinOut[g] = p8Out_r[g+`PPM_P8_ALT_LSB]
            ? displayDrivePins[g] : p8Out_r[g]; // [RULE13]
    end
endgenerate

// Interrupts: status bit per event, write one to clear
wire [7:0] irqEvt = {4'h0, extIrqPulse};
assign irqOut = |(irqSt_r & irqMsk_r);

wire wrIrqSt = regWrite && regAddr == `PPM_A_IRQST;
always @(posedge clock or negedge rstN)
begin
    if (!rstN)
        irqSt_r <= `PPM_RST_BYTE;
    else
        // A new event beats a simultaneous clear
        irqSt_r <= (irqSt_r & ~(wrIrqSt ? regWdata : 8'h00)) | irqEvt;
end

always @(posedge clock or negedge rstN)
begin
    if (!rstN)
    begin
        p0Out_r <= `PPM_RST_BYTE;
        p0Dir_r <= `PPM_RST_DIR;
        pullup_r <= `PPM_RST_BYTE;
        p1Out_r <= `PPM_RST_BYTE;
        p1Dir_r <= `PPM_RST_DIR;
        p2Out_r <= `PPM_RST_BYTE;
        p2Dir_r <= `PPM_RST_DIR;
        p3Out_r <= `PPM_RST_BYTE;
        p3Dir_r <= `PPM_RST_DIR;
        p7Out_r <= `PPM_RST_BYTE;
        p7Dir_r <= `PPM_RST_DIR;
        p8Out_r <= `PPM_RST_BYTE;
        p9Out_r <= `PPM_RST_BYTE;
        p10Out_r <= `PPM_RST_BYTE;
        p11Out_r <= `PPM_RST_BYTE;
        p11Dir_r <= `PPM_RST_DIR;
        p12Out_r <= `PPM_RST_BYTE;
        p12Dir_r <= `PPM_RST_DIR;
        alt0_r <= `PPM_RST_BYTE; // [RULE18]
        alt1_r <= `PPM_RST_BYTE; // [RULE18]
        alt2_r <= `PPM_RST_BYTE; // [RULE18]
        alt3_r <= `PPM_RST_BYTE; // [RULE18]
        alt89_r <= `PPM_RST_BYTE; // [RULE18]
        alt10_r <= `PPM_RST_BYTE; // [RULE18]
        alt11_r <= `PPM_RST_BYTE; // [RULE18]
        alt12_r <= `PPM_RST_BYTE; // [RULE18]
        edge_r <= `PPM_RST_EDGE;
        irqMsk_r <= `PPM_RST_BYTE;
    end
    else if (regWrite)
    begin
        case (regAddr)
            `PPM_A_P0OUT: p0Out_r <= regWdata;
            `PPM_A_P0DIR: p0Dir_r <= regWdata; // [RULE3]
            `PPM_A_PULLUP: pullup_r <= regWdata;
            `PPM_A_P1OUT: p1Out_r <= regWdata;
            `PPM_A_P1DIR: p1Dir_r <= regWdata; // [RULE8]
            `PPM_A_P2OUT: p2Out_r <= regWdata;
            `PPM_A_P2DIR: p2Dir_r <= regWdata;
            `PPM_A_P3OUT: p3Out_r <= regWdata;
            `PPM_A_P3DIR: p3Dir_r <= regWdata; // [RULE11]
            `PPM_A_P7OUT: p7Out_r <= regWdata;
            `PPM_A_P7DIR: p7Dir_r <= regWdata; // [RULE12]
            `PPM_A_P8OUT: p8Out_r <= regWdata;
            `PPM_A_P9OUT: p9Out_r <= regWdata;
            `PPM_A_P10OUT: p10Out_r <= regWdata;
            `PPM_A_P11OUT: p11Out_r <= regWdata;
            `PPM_A_P11DIR: p11Dir_r <= regWdata;
            `PPM_A_P12OUT: p12Out_r <= regWdata;
            `PPM_A_P12DIR: p12Dir_r <= regWdata;
            `PPM_A_ALT0: alt0_r <= regWdata; // [RULE1]
            `PPM_A_ALT1: alt1_r <= regWdata; // [RULE1]
            `PPM_A_ALT2: alt2_r <= regWdata; // [RULE1]
            `PPM_A_ALT3: alt3_r <= regWdata; // [RULE1]
            `PPM_A_ALT89: alt89_r <= regWdata; // [RULE1]
            `PPM_A_ALT10: alt10_r <= regWdata; // [RULE1]
            `PPM_A_ALT11: alt11_r <= regWdata; // [RULE1]
            `PPM_A_ALT12: alt12_r <= regWdata; // [RULE1]
            `PPM_A_EDGE: edge_r <= regWdata; // [RULE5]
            `PPM_A_IRQMSK: irqMsk_r <= regWdata;
            default: ;
        endcase
    end
end

// Read data: one cycle after the strobe, zero otherwise
reg [7:0] rdMux;
always @*
begin
    case (regAddr)
        `PPM_A_P0OUT: rdMux = p0Out_r;
        `PPM_A_P0DIR: rdMux = p0Dir_r;
        `PPM_A_PULLUP: rdMux = pullup_r;
        `PPM_A_P1OUT: rdMux = p1Out_r;
        `PPM_A_P1DIR: rdMux = p1Dir_r;
        `PPM_A_P2OUT: rdMux = p2Out_r;
        `PPM_A_P2DIR: rdMux = p2Dir_r;
        `PPM_A_P3OUT: rdMux = p3Out_r;
        `PPM_A_P3DIR: rdMux = p3Dir_r;
        `PPM_A_P7OUT: rdMux = p7Out_r;
        `PPM_A_P7DIR: rdMux = p7Dir_r;
        `PPM_A_P8OUT: rdMux = p8Out_r;
        `PPM_A_P9OUT: rdMux = p9Out_r;
        `PPM_A_P10OUT: rdMux = p10Out_r;
        `PPM_A_P11OUT: rdMux = p11Out_r;
        `PPM_A_P11DIR: rdMux = p11Dir_r;
        `PPM_A_P12OUT: rdMux = p12Out_r;
        `PPM_A_P12DIR: rdMux = p12Dir_r;
        `PPM_A_ALT0: rdMux = alt0_r;
        `PPM_A_ALT1: rdMux = alt1_r;
        `PPM_A_ALT2: rdMux = alt2_r;
        `PPM_A_ALT3: rdMux = alt3_r;
        `PPM_A_ALT89: rdMux = alt89_r;
        `PPM_A_ALT10: rdMux = alt10_r;
        `PPM_A_ALT11: rdMux = alt11_r;
        `PPM_A_ALT12: rdMux = alt12_r;
        `PPM_A_EDGE: rdMux = edge_r;
        `PPM_A_IRQST: rdMux = irqSt_r;
        `PPM_A_IRQMSK: rdMux = irqMsk_r;
        `PPM_A_PIN0: rdMux = {3'h0, p0In};
        `PPM_A_PIN1: rdMux = p1In;
        `PPM_A_PIN2: rdMux = p2In;
        default: rdMux = 8'h00;
    endcase
end

always @(posedge clock or negedge rstN)
begin
    if (!rstN)
        regRdata <= `PPM_RST_BYTE;
    else
        regRdata <= regRead ? rdMux : 8'h00;
end

endmodule
`default_nettype wire

// ---- rtl/ppm_map.vh ----
`ifndef PPM_MAP_VH
`define PPM_MAP_VH
// Register indices on the plain register port
`define PPM_A_P0OUT 5'h00
`define PPM_A_P0DIR 5'h01
`define PPM_A_PULLUP 5'h02
`define PPM_A_P1OUT 5'h03
`define PPM_A_P1DIR 5'h04
`define PPM_A_P2OUT 5'h05
`define PPM_A_P2DIR 5'h06
`define PPM_A_P3OUT 5'h07
`define PPM_A_P3DIR 5'h08
`define PPM_A_P7OUT 5'h09
`define PPM_A_P7DIR 5'h0a
`define PPM_A_P8OUT 5'h0b
`define PPM_A_P9OUT 5'h0c
`define PPM_A_P10OUT 5'h0d
`define PPM_A_P11OUT 5'h0e
`define PPM_A_P11DIR 5'h0f
`define PPM_A_P12OUT 5'h10
`define PPM_A_P12DIR 5'h11
`define PPM_A_ALT0 5'h12
`define PPM_A_ALT1 5'h13
`define PPM_A_ALT2 5'h14
`define PPM_A_ALT3 5'h15
`define PPM_A_ALT89 5'h16
`define PPM_A_ALT10 5'h17
`define PPM_A_ALT11 5'h18
`define PPM_A_ALT12 5'h19
`define PPM_A_EDGE 5'h1a
`define PPM_A_IRQST 5'h1b
`define PPM_A_IRQMSK 5'h1c
`define PPM_A_PIN0 5'h1d
`define PPM_A_PIN1 5'h1e
`define PPM_A_PIN2 5'h1f
// Port 8 alternate selects sit in its output latch from this bit up
`define PPM_P8_ALT_LSB 3'h4
// Reset values
`define PPM_RST_BYTE 8'h00
`define PPM_RST_DIR 8'hff
`define PPM_RST_EDGE 8'h00
// Edge select codes, two bits per input
`define PPM_EDGE_FALL 2'h0
`define PPM_EDGE_RISE 2'h1
`define PPM_EDGE_BOTH 2'h2
`endif

// ---- sim/ppm_mux_props.sv ----
`default_nettype none
module ppm_mux_props (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic progVoltagePin,
    input wire logic romProgMode,
    input wire logic [4:0] port0PinOe,
    input wire logic [4:0] port0PullupEn,
    input wire logic [7:0] port1PinOe,
    input wire logic [7:0] port1PullupEn,
    input wire logic [7:0] analogIn,
    input wire logic [3:0] extIrqPulse,
    input wire logic timer16CaptureTrig,
    input wire logic [4:0] port7PinOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    prog_mode_a: assert property (progVoltagePin |-> ##2 romProgMode)
        else $error("programming mode not entered");
    p0_input_only_a: assert property (port0PinOe[0] == 1'b0
        && port0PinOe[4] == 1'b0) else $error("input-only pin driven");
    p0_pullup_dir_a: assert property ((port0PullupEn & port0PinOe) == 5'h00)
        else $error("pull-up on driven port 0 pin");
    p1_pullup_dir_a: assert property ((port1PullupEn & port1PinOe) == 8'h00)
        else $error("pull-up on driven port 1 pin");
    analog_pullup_a: assert property ((analogIn & port1PullupEn) == 8'h00)
        else $error("pull-up on analog pin");
    capture_trig_a: assert property (timer16CaptureTrig == extIrqPulse[0])
        else $error("capture trigger differs from edge pulse");
    pulse_width_a: assert property (extIrqPulse[0] |=> !extIrqPulse[0])
        else $error("edge pulse longer than one cycle");
    open_drain_a: assert property (port7PinOut == 5'h00)
        else $error("open-drain port drives high");
    reset_plain_a: assert property ($rose(reset_n) |-> ##2
        (analogIn == 8'h00 && port1PinOe == 8'h00))
        else $error("pin not in plain input mode after reset");
endmodule
bind ppm_port_pin_function_mux ppm_mux_props u_props (.*);
`default_nettype wire

// ---- sim/ppm_board.sv ----
`default_nettype none
module ppm_board (
    input wire logic [4:0] port0PinOut,
    input wire logic [4:0] port0PinOe,
    input wire logic [4:0] port0PullupEn,
    input wire logic [4:0] ext0,
    output logic [4:0] port0PinIn,
    input wire logic [7:0] port1PinOut,
    input wire logic [7:0] port1PinOe,
    input wire logic [7:0] port1PullupEn,
    input wire logic [7:0] ext1,
    output logic [7:0] port1PinIn,
    input wire logic [4:0] port7PinOe,
    input wire logic [4:0] ext7,
    output logic [4:0] port7PinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven pins follow the pull-up, else the board's own level
    assign port0PinIn = (port0PinOe & port0PinOut)
        | (~port0PinOe & (port0PullupEn | ext0));
    assign port1PinIn = (port1PinOe & port1PinOut)
        | (~port1PinOe & (port1PullupEn | ext1));
    assign port7PinIn = ~port7PinOe & ext7;
endmodule
`default_nettype wire

// ---- sim/test_ppm_port_pin_function_mux.sv ----
`default_nettype none
`include "ppm_map.vh"
module test_ppm_port_pin_function_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset_n, regWrite, regRead, irqOut, clockOutPin;
    logic beeperOutput, timer8CountIn1, timer8CountIn2, timer16CaptureTrig;
    logic timer16CountIn, updownCountIn, subclockCrystalIn;
    logic progVoltagePin, romProgMode, rdPend;
    logic [4:0] regAddr, port0PinIn, port0PinOut, port0PinOe, port0PullupEn;
    logic [4:0] port7PinIn, port7PinOut, port7PinOe, ext0, ext7;
    logic [7:0] regWdata, regRdata, analogIn, serialOut, serialOe, serialIn;
    logic [7:0] port1PinIn, port1PinOut, port1PinOe, port1PullupEn, ext1;
    logic [7:0] port2PinIn, port2PinOut, port2PinOe, port2PullupEn, r, v;
    logic [7:0] port3PinIn, port3PinOut, port3PinOe, port3PullupEn;
    logic [7:0] port9PinOut, port10PinOut, port11PinIn, port11PinOut;
    logic [7:0] port11PinOe, port12PinIn, port12PinOut, port12PinOe;
    logic [1:0] port8PinOut;
    logic [2:0] timerOutPins;
    logic [3:0] extIrqPulse;
    logic [33:0] displayDrivePins, d;
    logic [7:0] q[$];
    int errTotal, nChecks, capCnt, bc;
    int cnt[4];
    int b[4];
    ppm_port_pin_function_mux dut_u (.*);
    ppm_board board_u (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        nChecks++;
        if (g !== e)
        begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task go(input logic w, input logic rr, input logic [4:0] a,
            input logic [7:0] dd);
        regWrite <= w;
        regRead <= rr;
        regAddr <= a;
        regWdata <= dd;
        @(posedge clock);
    endtask
    task wr(input logic [4:0] a, input logic [7:0] dd);
        go(1'b1, 1'b0, a, dd);
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        q.push_back(e);
        go(1'b0, 1'b1, a, 8'h00);
    endtask
    task idle;
        go(1'b0, 1'b0, regAddr, 8'h00);
    endtask
    task look;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clock)
    begin
        if (rdPend)
            chk("regRdata", q.pop_front(), regRdata);
        rdPend <= regRead;
        for (int k = 0; k < 4; k++)
            cnt[k] += (extIrqPulse[k] === 1'b1);
        capCnt += (timer16CaptureTrig === 1'b1);
    end
    initial begin
        #200000;
        errTotal++;
        conclude;
    end
    initial begin
        {reset_n, regWrite, regRead, regAddr, regWdata, rdPend} = '0;
        {ext0, ext1, ext7, port2PinIn, port3PinIn, serialOut} = '0;
        {port11PinIn, port12PinIn, serialOe, timerOutPins} = '0;
        {clockOutPin, beeperOutput, displayDrivePins, progVoltagePin} = '0;
        r = 8'h1e;
        #1 chk("romProgMode", 1, romProgMode);
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        for (int a = 18; a < 26; a++)
            rd(a[4:0], 8'h00);
        rd(`PPM_A_P0DIR, 8'hff);
        idle;
        chk("romProgMode", 1'b0, romProgMode);
        $display("reset test done");
        r = lfsr(r);
        wr(`PPM_A_P0DIR, 8'h00);
        wr(`PPM_A_P0OUT, r);
        wr(`PPM_A_PULLUP, 8'h3f);
        wr(`PPM_A_P1DIR, 8'h33);
        wr(`PPM_A_ALT1, 8'h0f);
        idle;
        ext1 <= 8'hff;
        look;
        chk("p0Oe", 5'h0e, port0PinOe);
        chk("p0Out", r[3:1], port0PinOut[3:1]);
        chk("p0Pull", 5'h11, port0PullupEn);
        chk("p1Oe", 8'hc0, port1PinOe);
        chk("p1Pull", 8'h30, port1PullupEn);
        chk("analogIn", 8'h0f, analogIn);
        @(posedge clock);
        rd(`PPM_A_PIN0, {3'h0, 1'b1, r[3:1], 1'b1});
        r = lfsr(r);
        v = r;
        wr(`PPM_A_P3DIR, 8'h00);
        wr(`PPM_A_P3OUT, v);
        wr(`PPM_A_ALT3, 8'h67);
        wr(`PPM_A_P2DIR, 8'hff);
        wr(`PPM_A_ALT2, 8'hff);
        idle;
        {timerOutPins, clockOutPin, port2PinIn} <= {3'h5, 1'b1, r};
        {serialOut, serialOe} <= {r ^ 8'h3c, 8'h0f};
        look;
        chk("p3Out", {v[7], 2'h1, v[4:3], 3'h5}, port3PinOut);
        chk("p3Oe", 8'hff, port3PinOe);
        chk("serialIn", r, serialIn);
        chk("p2Out", r ^ 8'h3c, port2PinOut);
        chk("p2Oe", 8'h0f, port2PinOe);
        @(posedge clock);
        d = {r[1:0], r, r ^ 8'h5a, ~r, r};
        displayDrivePins <= d;
        for (int a = 22; a < 26; a++)
            wr(a[4:0], 8'hff);
        wr(`PPM_A_P8OUT, 8'h30);
        wr(`PPM_A_P7DIR, 8'h1a);
        idle;
        look;
        chk("p8Out", d[1:0], port8PinOut);
        chk("p9Out", d[9:2], port9PinOut);
        chk("p10Out", d[17:10], port10PinOut);
        chk("p11Out", d[25:18], port11PinOut);
        chk("p11Oe", 8'hff, port11PinOe);
        chk("p12Out", d[33:26], port12PinOut);
        chk("p12Oe", 8'hff, port12PinOe);
        chk("p7Oe", 5'h05, port7PinOe);
        @(posedge clock);
        wr(`PPM_A_ALT89, 8'h00);
        wr(`PPM_A_P8OUT, 8'h02);
        wr(`PPM_A_ALT3, 8'h00);
        idle;
        look;
        chk("p8Port", 2'h2, port8PinOut);
        chk("p3Port", v, port3PinOut);
        @(posedge clock);
        $display("port test done");
        wr(`PPM_A_P0DIR, 8'hff);
        wr(`PPM_A_PULLUP, 8'h00);
        wr(`PPM_A_IRQMSK, 8'h00);
        idle;
        look;
        @(posedge clock);
        wr(`PPM_A_ALT0, 8'h1f);
        for (int c = 0; c < 4; c++)
        begin
            wr(`PPM_A_EDGE, {2'h0, c[1:0], c[1:0], c[1:0]});
            wr(`PPM_A_IRQST, 8'h0f);
            idle;
            b = cnt;
            bc = capCnt;
            ext0 <= 5'h0f;
            repeat (5) @(posedge clock);
            chk("cntIn", 3'h6, {timer16CountIn, updownCountIn,
                subclockCrystalIn});
            ext0 <= 5'h00;
            look;
            chk("irq0", (c == 2) ? 2 : 1, cnt[0] - b[0]);
            chk("irq1", (c == 2) ? 2 : 1, cnt[1] - b[1]);
            chk("irq2", (c == 2) ? 2 : 1, cnt[2] - b[2]);
            chk("irq3", 1, cnt[3] - b[3]);
            chk("capture", (c == 2) ? 2 : 1, capCnt - bc);
            chk("irqMasked", 1'b0, irqOut);
            @(posedge clock);
        end
        rd(`PPM_A_IRQST, 8'h0f);
        wr(`PPM_A_IRQMSK, 8'h08);
        idle;
        look;
        chk("irqOn", 1'b1, irqOut);
        @(posedge clock);
        wr(`PPM_A_IRQST, 8'h08);
        rd(`PPM_A_IRQST, 8'h07);
        idle;
        look;
        chk("irqOff", 1'b0, irqOut);
        @(posedge clock);
        progVoltagePin <= 1'b1;
        look;
        chk("romProgMode", 1, romProgMode);
        $display("interrupt test done");
        conclude;
    end
endmodule
`default_nettype wire
